//--- rtl/dtod_decode.sv
// decoder and cycle budget for a part of the data transfer instruction group
`timescale 1ns/1ps

module dtod_decode (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                narrow_bus,
  input  wire logic                req_valid,
  output      logic                req_ready,
  input  wire dtod_pkg::dtod_req_t req,
  output      dtod_pkg::dtod_dec_t dec_out,
  output      logic                dec_valid,
  output      logic                exec_busy,
  output      logic                exec_done
);

  dtod_pkg::dtod_dec_t   dec_c;
  dtod_pkg::dtod_dec_t   dec_ff;
  dtod_pkg::dtod_state_t state_ff;
  dtod_pkg::dtod_state_t nxt_state;
  logic [5:0]            cnt_ff;
  logic [5:0]            nxt_cnt;

  logic                  mem_c;
  logic                  seg_move_c;
  logic                  word_extra_c;
  logic                  accept;
  logic                  start_c;

  // handshake side: a request is taken only while idle
  assign req_ready = (state_ff == dtod_pkg::DTOD_ST_IDLE);
  assign accept    = req_valid && req_ready;
  assign start_c   = accept && (dec_c.op != dtod_pkg::DTOD_OP_NONE);

  // mod field 11 selects a register operand
  assign mem_c = (req.modrm[7:6] != dtod_pkg::MOD_REG);

  // word surcharge applies to segment moves that reach memory over the narrow bus
  assign seg_move_c   = (req.opcode == dtod_pkg::OPC_SEG_LOAD) || (req.opcode == dtod_pkg::OPC_SEG_STORE);
  assign word_extra_c = narrow_bus && req.word_xfer && mem_c && seg_move_c;

  // opcode decode and cycle budget, combinational from the request
  always_comb begin
    dec_c          = '0;
    dec_c.op       = dtod_pkg::DTOD_OP_NONE;
    dec_c.reg_sel  = req.modrm[5:3];
    dec_c.mem_form = mem_c;
    unique case (req.opcode)

      dtod_pkg::OPC_SEG_LOAD: begin
        dec_c.op = dtod_pkg::DTOD_OP_COPY_OPERAND_TO_SEG;
        if (!mem_c) begin
          dec_c.cycles = dtod_pkg::CYC_SEG_LOAD_REG;
        end else if (narrow_bus) begin
          dec_c.cycles = dtod_pkg::CYC_SEG_LOAD_M8;
        end else begin
          dec_c.cycles = dtod_pkg::CYC_SEG_LOAD_M16;
        end
      end

      dtod_pkg::OPC_SEG_STORE: begin
        dec_c.op = dtod_pkg::DTOD_OP_COPY_OPERAND_FROM_SEG;
        if (!mem_c) begin
          dec_c.cycles = dtod_pkg::CYC_SEG_STORE_REG;
        end else if (narrow_bus) begin
          dec_c.cycles = dtod_pkg::CYC_SEG_STORE_M8;
        end else begin
          dec_c.cycles = dtod_pkg::CYC_SEG_STORE_M16;
        end
      end

      dtod_pkg::OPC_XLATE: begin
        // single-byte op: modrm is ignored, the table read is a memory access
        dec_c.op       = dtod_pkg::DTOD_OP_TABLE_LOOKUP_BYTE;
        dec_c.mem_form = 1'b1;
        dec_c.reg_sel  = '0;
        if (narrow_bus) begin
          dec_c.cycles = dtod_pkg::CYC_XLATE_8;
        end else begin
          dec_c.cycles = dtod_pkg::CYC_XLATE_16;
        end
      end

      dtod_pkg::OPC_EA_LOAD: begin
        dec_c.op     = dtod_pkg::DTOD_OP_COMPUTE_OPERAND_OFFSET;
        dec_c.cycles = dtod_pkg::CYC_EA_LOAD;
      end

      dtod_pkg::OPC_FAR_DSEG, dtod_pkg::OPC_FAR_XSEG: begin
        if (!mem_c) begin
          // register form has no far pointer to fetch
          dec_c.undef_op = 1'b1;
        end else begin
          if (req.opcode == dtod_pkg::OPC_FAR_DSEG) begin
            dec_c.op = dtod_pkg::DTOD_OP_LOAD_FAR_POINTER_DATA_SEGMENT;
          end else begin
            dec_c.op = dtod_pkg::DTOD_OP_LOAD_FAR_POINTER_EXTRA_SEGMENT;
          end
          if (narrow_bus) begin
            dec_c.cycles = dtod_pkg::CYC_FAR_8;
          end else begin
            dec_c.cycles = dtod_pkg::CYC_FAR_16;
          end
        end
      end

      dtod_pkg::OPC_FLG_TO_ACCH: begin
        dec_c.op       = dtod_pkg::DTOD_OP_FLAGS_TO_ACCUMULATOR_HIGH;
        dec_c.mem_form = 1'b0;
        dec_c.reg_sel  = '0;
        dec_c.cycles   = dtod_pkg::CYC_FLG_TO_ACCH;
      end

      dtod_pkg::OPC_ACCH_TO_FLG: begin
        dec_c.op       = dtod_pkg::DTOD_OP_ACCUMULATOR_HIGH_TO_FLAGS;
        dec_c.mem_form = 1'b0;
        dec_c.reg_sel  = '0;
        dec_c.cycles   = dtod_pkg::CYC_ACCH_TO_FLG;
      end

      default: begin
        // other opcodes belong to other decoders
        dec_c.mem_form = 1'b0;
        dec_c.not_mine = 1'b1;
      end
    endcase
    // only the segment moves carry the word surcharge here
    if (word_extra_c) begin
      dec_c.cycles = 6'(dec_c.cycles + dtod_pkg::CYC_WORD_EXTRA_8);
    end
  end

  // execution sequencer: idle, count the budget, one done pulse
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)

      dtod_pkg::DTOD_ST_IDLE: begin
        if (start_c) begin
          nxt_state = dtod_pkg::DTOD_ST_EXEC;
        end
      end

      dtod_pkg::DTOD_ST_EXEC: begin
        // last counted clock hands over to the done pulse
        // a zero budget also ends here, so the sequencer cannot hang
        if (cnt_ff <= 6'h01) begin
          nxt_state = dtod_pkg::DTOD_ST_DONE;
        end
      end

      dtod_pkg::DTOD_ST_DONE: begin
        nxt_state = dtod_pkg::DTOD_ST_IDLE;
      end

      default: begin
        nxt_state = dtod_pkg::DTOD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff <= dtod_pkg::DTOD_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // budget loads on take and counts down while executing
  always_comb begin
    nxt_cnt = cnt_ff;
    if (accept) begin
      nxt_cnt = dec_c.cycles;
    end else if (state_ff == dtod_pkg::DTOD_ST_EXEC && cnt_ff != '0) begin
      nxt_cnt = 6'(cnt_ff - 6'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // one-cycle decode strobe after each take
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= accept;
    end
  end

  // decode is held until the next request is taken
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dec_ff <= '0;
    end else if (accept) begin
      dec_ff <= dec_c;
    end
  end

  assign dec_out   = dec_ff;

  // status outputs follow the sequencer state
  assign exec_busy = (state_ff == dtod_pkg::DTOD_ST_EXEC);
  assign exec_done = (state_ff == dtod_pkg::DTOD_ST_DONE);

endmodule

//--- rtl/dtod_pkg.sv
// shared types and constants for the data transfer opcode decoder
package dtod_pkg;

  localparam logic [7:0] OPC_SEG_LOAD  = 8'h8E;
  localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
  localparam logic [7:0] OPC_XLATE     = 8'hD7;
  localparam logic [7:0] OPC_EA_LOAD   = 8'h8D;
  localparam logic [7:0] OPC_FAR_DSEG    = 8'hC5;
  localparam logic [7:0] OPC_FAR_XSEG    = 8'hC4;
  localparam logic [7:0] OPC_FLG_TO_ACCH = 8'h9F;
  localparam logic [7:0] OPC_ACCH_TO_FLG = 8'h9E;

  localparam logic [1:0] MOD_REG = 2'h3;

  localparam logic [5:0] CYC_SEG_LOAD_REG   = 6'h02;
  localparam logic [5:0] CYC_SEG_LOAD_M16   = 6'h09;
  localparam logic [5:0] CYC_SEG_LOAD_M8    = 6'h0D;
  localparam logic [5:0] CYC_SEG_STORE_REG  = 6'h02;
  localparam logic [5:0] CYC_SEG_STORE_M16  = 6'h0B;
  localparam logic [5:0] CYC_SEG_STORE_M8   = 6'h0F;
  localparam logic [5:0] CYC_XLATE_16       = 6'h0B;
  localparam logic [5:0] CYC_XLATE_8        = 6'h0F;
  localparam logic [5:0] CYC_EA_LOAD        = 6'h06;
  localparam logic [5:0] CYC_FAR_16         = 6'h12;
  localparam logic [5:0] CYC_FAR_8          = 6'h1A;
  localparam logic [5:0] CYC_FLG_TO_ACCH    = 6'h02;
  localparam logic [5:0] CYC_ACCH_TO_FLG    = 6'h03;
  localparam logic [5:0] CYC_WORD_EXTRA_8   = 6'h04;

  typedef enum logic [3:0] {
    DTOD_OP_NONE                          = 4'h0,
    DTOD_OP_COPY_OPERAND_TO_SEG           = 4'h1,
    DTOD_OP_COPY_OPERAND_FROM_SEG         = 4'h2,
    DTOD_OP_TABLE_LOOKUP_BYTE             = 4'h3,
    DTOD_OP_COMPUTE_OPERAND_OFFSET        = 4'h4,
    DTOD_OP_LOAD_FAR_POINTER_DATA_SEGMENT = 4'h5,
    DTOD_OP_LOAD_FAR_POINTER_EXTRA_SEGMENT = 4'h6,
    DTOD_OP_FLAGS_TO_ACCUMULATOR_HIGH     = 4'h7,
    DTOD_OP_ACCUMULATOR_HIGH_TO_FLAGS     = 4'h8
  } dtod_op_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic       modrm_ok;
    logic       word_xfer;
  } dtod_req_t;

  typedef struct packed {
    dtod_op_t   op;
    logic       mem_form;
    logic [2:0] reg_sel;
    logic [5:0] cycles;
    logic       undef_op;
    logic       not_mine;
  } dtod_dec_t;

  typedef enum logic [1:0] {
    DTOD_ST_IDLE = 2'b00,
    DTOD_ST_EXEC = 2'b01,
    DTOD_ST_DONE = 2'b11
  } dtod_state_t;

endpackage

//--- test/dtod_asserts.sv
// port checks for the opcode decoder
`timescale 1ns/1ps
module dtod_asserts (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic                narrow_bus,
  input wire logic                req_valid,
  input wire logic                req_ready,
  input wire dtod_pkg::dtod_req_t req,
  input wire dtod_pkg::dtod_dec_t dec_out,
  input wire logic                dec_valid,
  input wire logic                exec_busy,
  input wire logic                exec_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic tk;
  logic mem;
  assign tk  = req_valid && req_ready;
  assign mem = req.modrm[7:6] != 2'h3;
  AST_SEG_LD: assert property (tk && req.opcode == 8'h8E && !mem |=> dec_out.cycles == 6'h02)
    else $error("seg load reg count");
  AST_SEG_ST: assert property (tk && req.opcode == 8'h8C && mem && narrow_bus && !req.word_xfer
    |=> dec_out.cycles == 6'h0F) else $error("seg store count");
  AST_WORD: assert property (tk && req.opcode == 8'h8E && mem && narrow_bus && req.word_xfer
    |=> dec_out.cycles == 6'h11) else $error("word surcharge");
  AST_XLATE: assert property (tk && req.opcode == 8'hD7 && narrow_bus |=> dec_out.cycles == 6'h0F)
    else $error("translate count");
  AST_EA: assert property (tk && req.opcode == 8'h8D |=> dec_out.cycles == 6'h06 && dec_valid)
    else $error("offset count");
  AST_FAR_DATA: assert property (tk && req.opcode == 8'hC5 && mem && !narrow_bus
    |=> dec_out.op == dtod_pkg::DTOD_OP_LOAD_FAR_POINTER_DATA_SEGMENT && dec_out.cycles == 6'h12)
    else $error("far load decode");
  AST_FAR_REG: assert property (tk && req.opcode[7:1] == 7'h62 && !mem
    |=> dec_out.undef_op && !exec_busy ##1 !exec_done) else $error("far reg form ran");
  AST_FLG_COPY: assert property (tk && req.opcode == 8'h9F |=> exec_busy [*2] ##1 exec_done)
    else $error("flags copy timing");
  AST_FLG_LOAD: assert property (tk && req.opcode == 8'h9E |=> exec_busy [*3] ##1 exec_done)
    else $error("flags load timing");
  cover property (tk && req.opcode == 8'h8E && narrow_bus && req.word_xfer);
  cover property (exec_done);
  cover property (dec_valid && dec_out.undef_op);
endmodule

//--- test/tb_data_transfer_opcode_decode.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("Error t=%0t %h %h", $time, a, b); end end
module tb_data_transfer_opcode_decode;
  logic                mclk;
  logic                reset_n;
  logic                narrow_bus;
  logic                req_valid;
  logic                req_ready;
  logic                dec_valid;
  logic                exec_busy;
  logic                exec_done;
  dtod_pkg::dtod_req_t req;
  dtod_pkg::dtod_dec_t dec_out;
  int                  n_fail = 0;
  int                  checks_done = 0;
  dtod_decode i_dtod_decode (.mclk, .reset_n, .narrow_bus, .req_valid, .req_ready, .req, .dec_out,
    .dec_valid, .exec_busy, .exec_done);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  task end_sim;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one request, then decode and execution length
  task run(input logic [7:0] o, m, input logic w, n, input logic [3:0] eo, input logic [5:0] ec);
    logic [5:0] k;
    while (req_ready !== 1'h1) @(posedge mclk) #1;
    req_valid = 1'h1;
    req = '{o, m, 1'h1, w};
    narrow_bus = n;
    @(posedge mclk) #1;
    req_valid = 1'h0;
    `CHK(dec_valid, 1'h1)
    `CHK(dec_out.op, eo)
    if (eo != 4'h0) begin
      `CHK(dec_out.cycles, ec)
      `CHK(exec_busy, 1'h1)
      k = 6'h00;
      while (exec_done !== 1'h1 && k < 6'h3F) begin
        @(posedge mclk) #1;
        k++;
      end
      `CHK(k, ec)
    end else begin
      `CHK(req_ready, 1'h1)
      `CHK(exec_busy, 1'h0)
      @(posedge mclk) #1;
    end
  endtask
  task t_seg;
    run(8'h8E, 8'hD8, 1'h1, 1'h1, 4'h1, 6'h02);
    run(8'h8E, 8'h1E, 1'h0, 1'h0, 4'h1, 6'h09);
    run(8'h8E, 8'h1E, 1'h0, 1'h1, 4'h1, 6'h0D);
    run(8'h8E, 8'h1E, 1'h1, 1'h1, 4'h1, 6'h11);
    run(8'h8C, 8'hC0, 1'h0, 1'h1, 4'h2, 6'h02);
    run(8'h8C, 8'h06, 1'h1, 1'h0, 4'h2, 6'h0B);
    run(8'h8C, 8'h06, 1'h0, 1'h1, 4'h2, 6'h0F);
    run(8'h8C, 8'h06, 1'h1, 1'h1, 4'h2, 6'h13);
  endtask
  task t_misc;
    run(8'hD7, 8'h00, 1'h0, 1'h0, 4'h3, 6'h0B);
    run(8'hD7, 8'h00, 1'h0, 1'h1, 4'h3, 6'h0F);
    `CHK(dec_out.mem_form, 1'h1)
    run(8'h8D, 8'h46, 1'h0, 1'h1, 4'h4, 6'h06);
    run(8'h9F, 8'h00, 1'h0, 1'h1, 4'h7, 6'h02);
    `CHK(dec_out.mem_form, 1'h0)
    run(8'h9E, 8'h00, 1'h0, 1'h0, 4'h8, 6'h03);
  endtask
  task t_far;
    run(8'hC5, 8'h2E, 1'h1, 1'h0, 4'h5, 6'h12);
    `CHK(dec_out.reg_sel, 3'h5)
    run(8'hC5, 8'h2E, 1'h1, 1'h1, 4'h5, 6'h1A);
    run(8'hC4, 8'h2E, 1'h1, 1'h0, 4'h6, 6'h12);
    run(8'hC4, 8'h2E, 1'h1, 1'h1, 4'h6, 6'h1A);
    run(8'hC5, 8'hC1, 1'h0, 1'h0, 4'h0, 6'h00);
    `CHK(dec_out.undef_op, 1'h1)
    run(8'hC4, 8'hC1, 1'h0, 1'h1, 4'h0, 6'h00);
    run(8'h90, 8'h00, 1'h0, 1'h0, 4'h0, 6'h00);
    `CHK(dec_out.not_mine, 1'h1)
  endtask
  initial begin
    reset_n = 1'h0;
    req_valid = 1'h0;
    req = '0;
    narrow_bus = 1'h0;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'h1;
    t_seg;
    t_misc;
    t_far;
    end_sim;
  end
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
endmodule
bind dtod_decode dtod_asserts i_dtod_asserts (.mclk, .reset_n, .narrow_bus, .req_valid, .req_ready, .req,
  .dec_out, .dec_valid, .exec_busy, .exec_done);
